// ===== verilog/lcd_frame_timing_control.sv
// lcd_frame_timing_control: clock source selection, frame prescaler,
// common phase generation and pixel write checking of an lcd driver.
// assumes an apb master on pclk; rc and timer1 oscillators arrive as
// slow asynchronous pins; core_sleep and pixel_write come from pclk logic.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - clock select bits 3:2 pick the source
// - system clock source is divided by 256
// - that divider is fixed, prescaler sets rate
// - rc oscillator off unless selected and enabled
// - mux bits 1:0 pick number of commons
// - one to four common phases match mode
// - static, 1/2, 1/4 frame is 128*(p+1)
// - 1/3 frame is 96*(p+1) source clocks
// - prescale register bits 3:0, upper read zero
// - control bit 7 enables the drive
// - control bit 6 set stops during sleep
module lcd_frame_timing_control
  import lcd_timing_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // oscillator pins and core status
  input wire logic rc_osc_clk,
  input wire logic timer1_osc_clk,
  input wire logic core_sleep,
  input wire logic pixel_write,
  // panel timing outputs
  output logic rc_osc_enable_r,
  output logic bias_enable_r,
  output logic [3:0] com_enable_r,
  output logic [3:0] com_phase_r,
  output logic frame_start_r,
  output logic write_error_flag_r,
  // interrupt
  output logic irq_r
);
  // registers
  logic [7:0] control_r;
  logic [3:0] prescale_r;
  logic [1:0] irq_status_r, irq_mask_r;
  // decoded controls
  logic drive_enable, stop_in_sleep, running;
  logic [1:0] clk_sel, mux_sel;
  // ticks
  logic rc_rise, t1_rise, sys_tick, src_tick, pre_tick;
  // frame position
  logic [6:0] frame_pos_r, frame_last;
  logic [1:0] phase_idx;
  logic write_allowed, bad_write;
  // bus decode
  logic setup_ph, wr_done, hit_ps, hit_ctl, hit_st, hit_mk;
  // all checks below sample on pclk and rest while in reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign drive_enable = control_r[DRIVE_EN_BIT];
  assign stop_in_sleep = control_r[STOP_SLEEP_BIT];
  assign clk_sel = control_r[CLK_SEL_HI:CLK_SEL_LO];
  assign mux_sel = control_r[MUX_SEL_HI:MUX_SEL_LO];

  // drive runs when enabled, and in sleep only if not told to stop
  assign running = drive_enable && !(core_sleep && stop_in_sleep);

  // address decode
  always_comb begin
    hit_ps = 1'b0;
    hit_ctl = 1'b0;
    hit_st = 1'b0;
    hit_mk = 1'b0;
    if (paddr == PRESCALE_ADDR) begin
      hit_ps = 1'b1;
    end else if (paddr == CONTROL_ADDR) begin
      hit_ctl = 1'b1;
    end else if (paddr == IRQ_STATUS_ADDR) begin
      hit_st = 1'b1;
    end else if (paddr == IRQ_MASK_ADDR) begin
      hit_mk = 1'b1;
    end
  end

  assign setup_ph = psel && !penable;
  assign wr_done = psel && penable && pready_r && pwrite && pstrb[0];

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel && penable && !pready_r;
    end
  end

  // read data and error are caught at setup and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= !(hit_ps || hit_ctl || hit_st || hit_mk);
      if (pwrite) begin
        prdata_r <= 32'h0000_0000;
      end else if (hit_ps) begin
        prdata_r <= {28'h000_0000, prescale_r};
      end else if (hit_ctl) begin
        prdata_r <= {24'h00_0000, control_r};
      end else if (hit_st) begin
        prdata_r <= {30'h0000_0000, irq_status_r};
      end else if (hit_mk) begin
        prdata_r <= {30'h0000_0000, irq_mask_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // control register; the error bit is set by hardware, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_r <= CONTROL_RST;
    end else begin
      if (wr_done && hit_ctl) begin
        control_r <= pwdata[7:0];
      end
      if (bad_write) begin
        control_r[WRITE_ERR_BIT] <= 1'b1;
      end
    end
  end

  // only the low nibble exists; upper bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= PRESCALE_RST;
    end else if (wr_done && hit_ps) begin
      prescale_r <= pwdata[3:0];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
    end else begin
      if (wr_done && hit_mk) begin
        irq_mask_r <= pwdata[1:0];
      end
      if (wr_done && hit_st) begin
        irq_status_r <= irq_status_r & ~pwdata[1:0];
      end
      if (frame_start_r) begin
        irq_status_r[IRQ_FRAME_BIT] <= 1'b1;
      end
      if (bad_write) begin
        irq_status_r[IRQ_WRITE_ERR_BIT] <= 1'b1;
      end
    end
  end

  // interrupt level follows status and mask one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // oscillator pins are asynchronous: synchronise before edge detect
  sync_edge rc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(rc_osc_clk),
    .rise_r(rc_rise)
  );

  sync_edge t1_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer1_osc_clk),
    .rise_r(t1_rise)
  );

  // fixed divide by 256 of the system clock; not software adjustable
  tick_divider #(.W(8)) sys_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .tick_in(1'b1),
    .last(SYS_DIV_LAST),
    .tick_r(sys_tick)
  );

  // source select; timer1 only ticks once software starts it
  always_comb begin
    if (clk_sel == SRC_SYSCLK) begin
      src_tick = sys_tick;
    end else if (clk_sel == SRC_TIMER1) begin
      src_tick = t1_rise;
    end else begin
      src_tick = rc_rise;
    end
  end

  // frame prescaler: one pulse per prescale+1 source ticks
  tick_divider #(.W(4)) frame_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .tick_in(src_tick),
    .last(prescale_r),
    .tick_r(pre_tick)
  );

  // per-mode fixed divider length
  assign frame_last = (mux_sel == MUX_THIRD) ? FRAME_LAST_96
                                             : FRAME_LAST_128;

  // frame position counts prescaled ticks; wrap marks a new frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_pos_r <= 7'h00;
      frame_start_r <= 1'b0;
    end else if (!running) begin
      frame_pos_r <= 7'h00;
      frame_start_r <= 1'b0;
    end else begin
      frame_start_r <= pre_tick && (frame_pos_r >= frame_last);
      if (pre_tick) begin
        // >= keeps a mode change mid-frame from running past the end
        frame_pos_r <= (frame_pos_r >= frame_last) ? 7'h00
                                                    : 7'(frame_pos_r + 1'b1);
      end
    end
  end

  // phase index: equal slices of the frame, one per common
  always_comb begin
    case (mux_sel)
      MUX_STATIC: phase_idx = 2'h0;
      MUX_HALF: phase_idx = {1'b0, frame_pos_r[6]};
      default: phase_idx = frame_pos_r[6:5]; // 32-tick slices
    endcase
  end

  // common outputs; phase 0 is the frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_enable_r <= 4'h0;
      com_phase_r <= 4'h0;
    end else begin
      case (mux_sel)
        MUX_STATIC: com_enable_r <= 4'h1;
        MUX_HALF: com_enable_r <= 4'h3;
        MUX_THIRD: com_enable_r <= 4'h7;
        default: com_enable_r <= 4'hF;
      endcase
      com_phase_r <= running ? 4'(4'h1 << phase_idx) : 4'h0;
    end
  end

  // pixel data may change only in the last common slice of a frame
  // when the drive is idle nothing is being fetched
  assign write_allowed = !running ||
                         ((phase_idx == mux_sel) && !core_sleep);
  assign bad_write = pixel_write && !write_allowed;

  // outputs mirrored from control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_osc_enable_r <= 1'b0;
      bias_enable_r <= 1'b0;
      write_error_flag_r <= 1'b0;
    end else begin
      // rc runs only when picked and the drive is on, saving its current
      rc_osc_enable_r <= running && clk_sel[1];
      bias_enable_r <= control_r[BIAS_BIT];
      write_error_flag_r <= control_r[WRITE_ERR_BIT];
    end
  end

  // helper: divider gap in pclk, prescaler and frame lengths in ticks;
  // the gap saturates at 256 so a stalled divider cannot look correct
  logic [4:0] src_cnt_r;
  logic [7:0] pre_cnt_r;
  logic [8:0] sys_gap_r;
  logic cfg_clean_r, sys_seen_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_cnt_r <= 5'h00;
      pre_cnt_r <= 8'h00;
      sys_gap_r <= 9'h000;
      cfg_clean_r <= 1'b0;
      sys_seen_r <= 1'b0;
    end else begin
      if (!running || sys_tick) begin
        sys_gap_r <= 9'h000;
      end else if (!sys_gap_r[8]) begin
        sys_gap_r <= 9'(sys_gap_r + 1'b1);
      end
      sys_seen_r <= running && (sys_seen_r || sys_tick);
      if (pre_tick) begin
        src_cnt_r <= 5'h00;
      end else if (src_tick) begin
        src_cnt_r <= 5'(src_cnt_r + 1'b1);
      end
      if (frame_start_r) begin
        pre_cnt_r <= 8'h00;
      end else if (pre_tick) begin
        pre_cnt_r <= 8'(pre_cnt_r + 1'b1);
      end
      if (!running || (wr_done && (hit_ctl || hit_ps))) begin
        cfg_clean_r <= 1'b0;
      end else if (frame_start_r) begin
        cfg_clean_r <= 1'b1;
      end
    end
  end

  sys_div_a: assert property (
    sys_seen_r |-> (int'(sys_gap_r) < SYS_DIV_CYC) &&
      (sys_tick == (int'(sys_gap_r) == SYS_DIV_CYC - 1)))
    else $error("system clock divider is not 256");
  src_mux_a: assert property (
    (clk_sel == SRC_TIMER1) |-> (src_tick == t1_rise))
    else $error("timer1 source not routed");
  rc_power_a: assert property (
    (!drive_enable || !clk_sel[1]) |=> !rc_osc_enable_r)
    else $error("rc oscillator left running");
  com_count_a: assert property (
    1'b1 |=> ($countones(com_enable_r) == int'($past(mux_sel)) + 1))
    else $error("active common count mismatches mode");
  phase_in_mode_a: assert property (
    $stable(com_enable_r) |->
      ($onehot0(com_phase_r) && ((com_phase_r & ~com_enable_r) == 4'h0)))
    else $error("common phase outside selected mode");
  pre_reload_a: assert property (
    pre_tick && cfg_clean_r && $past(pre_tick == 1'b0) |->
      (src_cnt_r + 5'h01 >= 5'(prescale_r) + 5'h01))
    else $error("prescaler reloaded early");
  frame_len_a: assert property (
    frame_start_r && cfg_clean_r |->
      (pre_cnt_r == ((mux_sel == MUX_THIRD) ? 8'h60 : 8'h80)))
    else $error("frame length wrong for mode");
  ps_read_a: assert property (
    setup_ph && !pwrite && hit_ps |=> (prdata_r[31:4] == 28'h000_0000))
    else $error("prescale upper bits not zero");
  write_err_sticky_a: assert property (
    bad_write |=> control_r[WRITE_ERR_BIT] ##1 write_error_flag_r)
    else $error("write error flag not raised");
  sleep_stop_a: assert property (
    (core_sleep && stop_in_sleep) |=> (com_phase_r == 4'h0))
    else $error("drive continued in sleep");
endmodule
`default_nettype wire

// ===== verilog/lcd_timing_pkg.sv
// lcd_timing_pkg: shared constants of the lcd frame timing core.
// assumes an apb slave with 32-bit data, registers in the low byte.
package lcd_timing_pkg;

  // printed register indices; byte address is four times the index
  localparam logic [11:0] PRESCALE_IDX = 12'h10E;
  localparam logic [11:0] CONTROL_IDX = 12'h10F;
  localparam logic [11:0] IRQ_STATUS_IDX = 12'h110;
  localparam logic [11:0] IRQ_MASK_IDX = 12'h111;
  localparam logic [11:0] PRESCALE_ADDR = 12'h438;
  localparam logic [11:0] CONTROL_ADDR = 12'h43C;
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h440;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h444;

  // lcd_control field positions
  localparam int DRIVE_EN_BIT = 7;
  localparam int STOP_SLEEP_BIT = 6;
  localparam int WRITE_ERR_BIT = 5;
  localparam int BIAS_BIT = 4;
  localparam int CLK_SEL_HI = 3;
  localparam int CLK_SEL_LO = 2;
  localparam int MUX_SEL_HI = 1;
  localparam int MUX_SEL_LO = 0;

  // irq status / mask bit positions
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_WRITE_ERR_BIT = 1;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [3:0] PRESCALE_RST = 4'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // clock source codes; 10 and 11 both pick the rc oscillator
  localparam logic [1:0] SRC_SYSCLK = 2'h0;
  localparam logic [1:0] SRC_TIMER1 = 2'h1;

  // multiplex codes
  localparam logic [1:0] MUX_STATIC = 2'h0;
  localparam logic [1:0] MUX_HALF = 2'h1;
  localparam logic [1:0] MUX_THIRD = 2'h2;
  localparam logic [1:0] MUX_QUARTER = 2'h3;

  // fixed dividers, in cycles of their input
  localparam logic [7:0] SYS_DIV_LAST = 8'hFF;   // divide by 256
  localparam int SYS_DIV_CYC = 256;
  localparam logic [6:0] FRAME_LAST_128 = 7'h7F; // 128 prescaled ticks
  localparam logic [6:0] FRAME_LAST_96 = 7'h5F;  // 96 prescaled ticks

endpackage

// ===== verilog/sync_edge.sv
// sync_edge: two-flop synchroniser for an asynchronous clock pin, plus
// a one-cycle pulse on each rising edge seen after synchronising.
// assumes the pin toggles well below half the pclk rate.
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and pulse
  input wire logic pin,
  output logic rise_r
);
  logic meta_r;
  logic stable_r;
  logic last_r;

  // only stable_r is looked at by the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      stable_r <= 1'b0;
      last_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= pin;
      stable_r <= meta_r;
      last_r <= stable_r;
      rise_r <= stable_r & ~last_r;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/tick_divider.sv
// tick_divider: counts input ticks and pulses once every last+1 ticks.
// assumes last is held steady by the caller; a change applies at once, and one below the count runs on to overflow.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic tick_in,
  input wire logic [W-1:0] last,
  // output pulse
  output logic tick_r
);
  logic [W-1:0] cnt_r;

  // idle counter restarts from zero so a new run starts a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_in && (cnt_r == last);
      if (tick_in) begin
        cnt_r <= (cnt_r == last) ? '0 : W'(cnt_r + 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/lcd_panel_model.sv
// lcd_panel_model: far side of the timing core, the two oscillators.
// assumes pclk of 8 ns; both oscillators run at eight pclk a period.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  // run requests
  input wire logic t1_run,
  input wire logic rc_run,
  // oscillator pins
  output logic t1_clk,
  output logic rc_clk
);
  // timer1 crystal only swings once software has enabled it
  initial begin
    t1_clk = 1'b0;
    #3;
    forever begin
      wait (t1_run === 1'b1);
      #32 t1_clk = 1'b1;
      #32 t1_clk = 1'b0;
    end
  end

  // rc oscillator stands at 0 while powered down, never free running
  initial begin
    rc_clk = 1'b0;
    #5;
    forever begin
      wait (rc_run === 1'b1);
      #32 rc_clk = 1'b1;
      #32 rc_clk = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== bench/lcd_frame_timing_control_test.sv
// lcd_frame_timing_control_test: apb tasks and scenario sequence.
// assumes the oscillator model drives both slow clock pins.
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_timing_control_test
  import lcd_timing_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, core_sleep, pixel_write;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_r, rd;
  logic pready_r, pslverr_r, err, rc_osc_clk, timer1_osc_clk, t1_en;
  logic rc_osc_enable_r, bias_enable_r, frame_start_r;
  logic write_error_flag_r, irq_r;
  logic [3:0] com_enable_r, com_phase_r;
  logic [4:0] msk;
  int fails, n_tests, gap, m, p, ex;

  // design under test; only byte lane 0 carries register data
  lcd_frame_timing_control u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .rc_osc_clk(rc_osc_clk), .timer1_osc_clk(timer1_osc_clk),
    .core_sleep(core_sleep), .pixel_write(pixel_write),
    .rc_osc_enable_r(rc_osc_enable_r), .bias_enable_r(bias_enable_r),
    .com_enable_r(com_enable_r), .com_phase_r(com_phase_r),
    .frame_start_r(frame_start_r),
    .write_error_flag_r(write_error_flag_r), .irq_r(irq_r)
  );

  // oscillators; rc power follows the design's own enable
  lcd_panel_model u_panel (
    .t1_run(t1_en), .rc_run(rc_osc_enable_r),
    .t1_clk(timer1_osc_clk), .rc_clk(rc_osc_clk)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task test_done;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // one apb transfer; held until pready is seen at a rising edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_r !== 1'b1 && k < 20);
    rd = prdata_r;
    err = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready_r !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // cycles up to the next frame start pulse, bounded
  task wait_frame;
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
    end while (frame_start_r !== 1'b1 && gap < 40000);
    if (frame_start_r !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask

  task pulse_pixel;
    @(posedge pclk);
    pixel_write <= 1'b1;
    @(posedge pclk);
    pixel_write <= 1'b0;
    tick(3);
  endtask

  initial begin
    {psel, penable, pwrite, core_sleep, pixel_write} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    fails = 0;
    n_tests = 0;
    t1_en = 1'b1; // timer1 oscillator enabled by software
    presetn = 1'b0;
    tick(12);
    presetn <= 1'b1;
    rdc(PRESCALE_ADDR, 32'h0);
    rdc(CONTROL_ADDR, 32'h0);
    rdc(IRQ_STATUS_ADDR, 32'h0);
    rdc(IRQ_MASK_ADDR, 32'h0);
    apb(PRESCALE_ADDR, 1'b1, 32'hFF);
    rdc(PRESCALE_ADDR, 32'h0F);
    apb(12'h000, 1'b0, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(CONTROL_ADDR, 1'b1, 32'h10);
    tick(2);
    chk(bias_enable_r, 1'b1);
    // every mux mode on timer1; frame is ticks*(p+1) of 8 pclk each
    for (m = 0; m < 4; m++) begin
      p = (m == 3) ? 0 : m;
      apb(PRESCALE_ADDR, 1'b1, p);
      apb(CONTROL_ADDR, 1'b1, 32'h84 | m);
      tick(2);
      msk = (5'h02 << m) - 5'h01;
      chk(com_enable_r, msk[3:0]);
      chk(rc_osc_enable_r, 1'b0);
      wait_frame();
      wait_frame();
      ex = ((m == 2) ? 96 : 128) * (p + 1) * 8;
      chk(gap, ex);
      // the frame closes on the highest common, then reopens on common 0
      chk(com_phase_r, msk[3:0] ^ (msk[3:0] >> 1));
      tick(1);
      chk(com_phase_r, 4'h1);
      apb(CONTROL_ADDR, 1'b1, 32'h00);
    end
    // stop in sleep halts commons, keep running in sleep does not
    apb(CONTROL_ADDR, 1'b1, 32'hC8);
    core_sleep <= 1'b1;
    tick(4);
    chk(com_phase_r, 4'h0);
    chk(rc_osc_enable_r, 1'b0);
    apb(CONTROL_ADDR, 1'b1, 32'h84);
    wait_frame();
    wait_frame();
    chk(gap, 1024);
    core_sleep <= 1'b0;
    // rc source, both rc codes; powered only when chosen and driving
    apb(CONTROL_ADDR, 1'b1, 32'h88);
    tick(2);
    chk(rc_osc_enable_r, 1'b1);
    wait_frame();
    wait_frame();
    chk(gap, 1024);
    apb(CONTROL_ADDR, 1'b1, 32'h8C);
    tick(2);
    chk(rc_osc_enable_r, 1'b1);
    apb(CONTROL_ADDR, 1'b1, 32'h0C);
    tick(2);
    chk(rc_osc_enable_r, 1'b0);
    // pixel write with drive off is allowed
    pulse_pixel();
    rdc(CONTROL_ADDR, 32'h0C);
    // pixel write in the first common slice is refused
    apb(IRQ_MASK_ADDR, 1'b1, 32'h2);
    apb(CONTROL_ADDR, 1'b1, 32'h87);
    wait_frame();
    chk(irq_r, 1'b0);
    pulse_pixel();
    chk(write_error_flag_r, 1'b1);
    chk(irq_r, 1'b1);
    rdc(CONTROL_ADDR, 32'hA7);
    rdc(IRQ_STATUS_ADDR, 32'h3);
    apb(IRQ_STATUS_ADDR, 1'b1, 32'h3);
    tick(2);
    chk(irq_r, 1'b0);
    rdc(CONTROL_ADDR, 32'hA7);
    apb(CONTROL_ADDR, 1'b1, 32'h87);
    rdc(CONTROL_ADDR, 32'h87);
    // system clock divided by a fixed 256
    apb(CONTROL_ADDR, 1'b1, 32'h00);
    apb(CONTROL_ADDR, 1'b1, 32'h80);
    wait_frame();
    wait_frame();
    chk(gap, 128 * 256);
    test_done();
  end
endmodule
`default_nettype wire
